// File: src/fsup_regs.vh
/*
  Register offsets, field positions, reset values and table values
  of the dual channel fault supervisor. Definitions only; included
  by bare name from the top-level design file.
*/
`ifndef FSUP_REGS_VH
`define FSUP_REGS_VH

// register offsets
`define FSUP_ADDR_LIMIT_CFG 8'h0e
`define FSUP_ADDR_LTIMER_CFG 8'h0f
`define FSUP_ADDR_MTIMER_CFG 8'h10
`define FSUP_ADDR_STATUS1 8'h11
`define FSUP_ADDR_STATUS2 8'h12
`define FSUP_ADDR_ENABLE1 8'h13
`define FSUP_ADDR_ENABLE2 8'h14

// reset values
`define FSUP_RST_LIMIT_CFG 8'h0f
`define FSUP_RST_LTIMER_CFG 8'h0a
`define FSUP_RST_MTIMER_CFG 8'h99
`define FSUP_RST_ENABLE1 8'h3c
`define FSUP_RST_ENABLE2 8'h0f
`define FSUP_RST_STATUS1 8'h20
`define FSUP_RST_STATUS2 8'h00

// field positions
`define FSUP_BIT_RFEN 6
`define FSUP_BIT_FBOEN 4
`define FSUP_BIT_OVEN 2
`define FSUP_BIT_UVEN 0
`define FSUP_BIT_ANALOG_ONLY_OVERVOLTAGE 7
`define FSUP_BIT_OCEN 4
`define FSUP_BIT_LIMEN 2
`define FSUP_BIT_ISOEN 0
`define FSUP_BIT_PC 5
`define FSUP_BIT_EVTCNT 4

// event thresholds and limit timer maxima
`define FSUP_EVT_T0 6'h01
`define FSUP_EVT_T1 6'h04
`define FSUP_EVT_T2 6'h10
`define FSUP_EVT_T3 6'h20
`define FSUP_LIM_M0 6'h04
`define FSUP_LIM_M1 6'h08
`define FSUP_LIM_M2 6'h10
`define FSUP_LIM_M3 6'h20

// main timer maxima, code 0 disables
`define FSUP_MAIN_OFF 14'h0000
`define FSUP_MAIN_M1 14'h03e8
`define FSUP_MAIN_M2 14'h05dc
`define FSUP_MAIN_M3 14'h07d0
`define FSUP_MAIN_M4 14'h09c4
`define FSUP_MAIN_M5 14'h0bb8
`define FSUP_MAIN_M6 14'h0dac
`define FSUP_MAIN_M7 14'h0fa0
`define FSUP_MAIN_M8 14'h1388
`define FSUP_MAIN_M9 14'h1770
`define FSUP_MAIN_M10 14'h1b58
`define FSUP_MAIN_M11 14'h1f40
`define FSUP_MAIN_M12 14'h2710
`define FSUP_MAIN_M13 14'h2ee0
`define FSUP_MAIN_M14 14'h36b0
`define FSUP_MAIN_M15 14'h3fff

`endif

// File: src/fsup_sync.v
/*
  Three-stage synchroniser for a bundle of asynchronous levels.
  Assumes each bit is a slow level; the output follows only once
  the second and third stages agree.
*/
`timescale 1ns/1ns
`default_nettype none
module fsup_sync #(
  parameter WIDTH = 16
) (
  input wire ref_clk,
  input wire srst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stg1_ff;
  reg [WIDTH-1:0] stg2_ff;
  reg [WIDTH-1:0] stg3_ff;
  integer i;

  // stage one is read by stage two only
  always @(posedge ref_clk) begin
    if (srst) begin
      stg1_ff <= {WIDTH{1'b0}};
      stg2_ff <= {WIDTH{1'b0}};
      stg3_ff <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stg1_ff <= async_in;
      stg2_ff <= stg1_ff;
      stg3_ff <= stg2_ff;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stg2_ff[i] == stg3_ff[i]) begin
          sync_out[i] <= stg3_ff[i];
        end
      end
    end
  end
endmodule // fsup_sync
`default_nettype wire

// File: src/fsup_chan.v
/*
  One channel's counters: limit event counter, 6-bit limit fault
  timer and 14-bit main fault timer. Timers advance on the channel
  switching clock tick, a one-cycle pulse on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module fsup_chan #(
  parameter LIM_W = 6,
  parameter MAIN_W = 14
) (
  input wire ref_clk,
  input wire srst,
  input wire tick,
  input wire clr,
  input wire evt,
  input wire [5:0] evt_thr,
  input wire [LIM_W-1:0] lim_max,
  input wire main_run,
  input wire [MAIN_W-1:0] main_max,
  output wire evt_hit,
  output wire lim_exp,
  output wire main_exp
);
  reg [5:0] evt_cnt_ff;
  reg [LIM_W-1:0] lim_cnt_ff;
  reg [MAIN_W-1:0] main_cnt_ff;

  assign evt_hit = (evt_cnt_ff >= evt_thr);
  assign lim_exp = evt_hit && (lim_cnt_ff >= lim_max);
  // a zero maximum means the main timer never expires
  assign main_exp = (main_max != {MAIN_W{1'b0}}) && (main_cnt_ff >= main_max);

  // counters saturate at their maximum and clear with the channel
  always @(posedge ref_clk) begin
    if (srst || clr) begin
      evt_cnt_ff <= 6'h00;
      lim_cnt_ff <= {LIM_W{1'b0}};
      main_cnt_ff <= {MAIN_W{1'b0}};
    end else begin
      if (evt && !evt_hit) begin
        evt_cnt_ff <= evt_cnt_ff + 6'h01;
      end
      if (evt_hit && tick && !lim_exp) begin
        lim_cnt_ff <= lim_cnt_ff + 1'b1;
      end
      if (!main_run) begin
        main_cnt_ff <= {MAIN_W{1'b0}};
      end else if (tick && !main_exp && main_max != {MAIN_W{1'b0}}) begin
        main_cnt_ff <= main_cnt_ff + 1'b1;
      end
    end
  end
endmodule // fsup_chan
`default_nettype wire

// File: src/fsup_top.v
/*
  Fault supervisor for a two-channel controller: limit and timer
  configuration, read-to-clear fault status, fault enables, and the
  per-channel fault decisions. Assumes an SPI front end that hands
  over decoded register writes, the end of a read command transfer
  and the end of the read response transfer as one-cycle strobes.
*/
// Function
// - event count field selects 1/4/16/32 events
// - count limit events, act at threshold
// - threshold field picks comparator level select
// - 6-bit limit timer on channel clock
// - limit timer maximum 4/8/16/32
// - dual phase: channel 1 limit timer only
// - 14-bit main timer on channel clock
// - main timer code table, zero disables
// - dual phase: single main timer both channels
// - status sets on fault, read clears gone ones
// - clear happens at end of response transfer
// - power cycled flag blocks enable until read
// - first status register bit layout
// - dual phase masks channel 2 UV/OV/OC/limit faults, not isolation or feedback open
// - undercurrent and overcurrent flags reported
// - limit status only after threshold reached
// - disabled faults leave fault pin alone
// - ramp enable 0 masks UV, CV limit
// - ramp enable 1 keeps faults during ramp
// - feedback open fault has no status bit
// - analog-only option hides overvoltage
// - sense pin open gated by enables
// - latched fault off until channel enable write
`timescale 1ns/1ns
`default_nettype none
`include "fsup_regs.vh"
module fsup_top #(
  parameter LIM_W = 6,
  parameter MAIN_W = 14
) (
  input wire ref_clk,
  input wire srst,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  input wire reg_rd_done,
  output reg [7:0] reg_rdata,
  input wire [1:0] cond_uv,
  input wire [1:0] cond_ov,
  input wire [1:0] cond_uc,
  input wire [1:0] cond_oc,
  input wire [1:0] cond_iso,
  input wire [1:0] cond_fbo,
  input wire [1:0] cond_limit,
  input wire cond_rto,
  input wire cond_tw,
  input wire [1:0] chan_tick,
  input wire [1:0] chan_running,
  input wire [1:0] soft_start_active,
  input wire [1:0] channel_enable_wr,
  input wire [7:0] fault_latch_cfg,
  input wire cv_mode,
  input wire dual_phase_mode,
  output wire power_cycled_flag,
  output wire [3:0] current_limit_threshold_select,
  output reg [1:0] chan_shutdown,
  output wire [1:0] fault_pin_out,
  output reg [1:0] fault_pin_oe
);
  // one-hot read clear tracker states
  localparam ST_IDLE = 3'b001;
  localparam ST_PEND1 = 3'b010;
  localparam ST_PEND2 = 3'b100;

  reg [7:0] limit_cfg_ff;
  reg [7:0] ltimer_cfg_ff;
  reg [7:0] mtimer_cfg_ff;
  reg [7:0] enable1_ff;
  reg [7:0] enable2_ff;
  reg [7:0] status1_ff;
  reg [7:0] status2_ff;
  reg [7:0] nxt_status1;
  reg [7:0] nxt_status2;
  reg [2:0] rd_state_ff;
  reg [2:0] nxt_rd_state;
  reg [1:0] latch_off_ff;
  reg [1:0] nxt_latch_off;
  reg [1:0] limit_sync_d_ff;

  wire [15:0] synced;
  wire [1:0] s_uv;
  wire [1:0] s_ov;
  wire [1:0] s_uc;
  wire [1:0] s_oc;
  wire [1:0] s_iso;
  wire [1:0] s_fbo;
  wire [1:0] s_limit;
  wire s_rto;
  wire s_tw;

  // analog comparator levels are asynchronous to ref_clk
  fsup_sync #(
    .WIDTH(16)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in({cond_rto, cond_tw, cond_limit, cond_fbo, cond_iso,
      cond_oc, cond_uc, cond_ov, cond_uv}),
    .sync_out(synced)
  );

  assign s_uv = synced[1:0];
  assign s_ov = synced[3:2];
  assign s_uc = synced[5:4];
  assign s_oc = synced[7:6];
  assign s_iso = synced[9:8];
  assign s_fbo = synced[11:10];
  assign s_limit = synced[13:12];
  assign s_tw = synced[14];
  assign s_rto = synced[15];

  // decode of the event count field, shared by both channels
  function [5:0] evt_thr_of;
    input [1:0] code;
    begin
      case (code)
        2'b00: evt_thr_of = `FSUP_EVT_T0;
        2'b01: evt_thr_of = `FSUP_EVT_T1;
        2'b10: evt_thr_of = `FSUP_EVT_T2;
        default: evt_thr_of = `FSUP_EVT_T3;
      endcase
    end
  endfunction

  // decode of the limit timer field
  function [5:0] lim_max_of;
    input [1:0] code;
    begin
      case (code)
        2'b00: lim_max_of = `FSUP_LIM_M0;
        2'b01: lim_max_of = `FSUP_LIM_M1;
        2'b10: lim_max_of = `FSUP_LIM_M2;
        default: lim_max_of = `FSUP_LIM_M3;
      endcase
    end
  endfunction

  // decode of the main timer field
  function [13:0] main_max_of;
    input [3:0] code;
    begin
      case (code)
        4'h0: main_max_of = `FSUP_MAIN_OFF;
        4'h1: main_max_of = `FSUP_MAIN_M1;
        4'h2: main_max_of = `FSUP_MAIN_M2;
        4'h3: main_max_of = `FSUP_MAIN_M3;
        4'h4: main_max_of = `FSUP_MAIN_M4;
        4'h5: main_max_of = `FSUP_MAIN_M5;
        4'h6: main_max_of = `FSUP_MAIN_M6;
        4'h7: main_max_of = `FSUP_MAIN_M7;
        4'h8: main_max_of = `FSUP_MAIN_M8;
        4'h9: main_max_of = `FSUP_MAIN_M9;
        4'ha: main_max_of = `FSUP_MAIN_M10;
        4'hb: main_max_of = `FSUP_MAIN_M11;
        4'hc: main_max_of = `FSUP_MAIN_M12;
        4'hd: main_max_of = `FSUP_MAIN_M13;
        4'he: main_max_of = `FSUP_MAIN_M14;
        default: main_max_of = `FSUP_MAIN_M15;
      endcase
    end
  endfunction

  // the comparator level select goes straight to the analog side
  assign current_limit_threshold_select = limit_cfg_ff[3:0];
  assign power_cycled_flag = status1_ff[`FSUP_BIT_PC];
  // open-drain pins only ever pull low
  assign fault_pin_out = 2'b00;

  // channel 2 UV, OV, OC and limit faults are ignored in dual phase; isolation and feedback open still act
  wire [1:0] ch_mask = {~dual_phase_mode, 1'b1};

  wire [1:0] en_rf = enable1_ff[7:6];
  wire [1:0] en_fbo = enable1_ff[5:4];
  wire [1:0] en_ov = enable1_ff[3:2];
  wire [1:0] en_uv = enable1_ff[1:0];
  wire ov_analog = enable2_ff[`FSUP_BIT_ANALOG_ONLY_OVERVOLTAGE];
  wire [1:0] en_oc = enable2_ff[5:4];
  wire [1:0] en_lim = enable2_ff[3:2];
  wire [1:0] en_iso = enable2_ff[1:0];

  // ramp window in which masking may apply
  wire [1:0] ramp_mask = soft_start_active & ~en_rf;

  // qualified fault levels that act on each channel
  wire [1:0] act_uv = s_uv & en_uv & ~ramp_mask & ch_mask;
  wire [1:0] act_ov = s_ov & en_ov & {2{~ov_analog}} & ch_mask;
  wire [1:0] act_oc = s_oc & en_oc & ch_mask;
  wire [1:0] act_iso = s_iso & en_iso & (en_oc | en_lim);
  wire [1:0] act_fbo = s_fbo & en_fbo;

  // a limit event is the rising edge of the synchronised level
  wire [1:0] limit_evt = s_limit & ~limit_sync_d_ff;
  wire [1:0] limit_gate = en_lim & ~(ramp_mask & {2{cv_mode}});
  wire [1:0] evt_q = limit_evt & limit_gate & ch_mask;

  // clear counters while the channel is down or blocked
  wire [1:0] chan_clr = ~chan_running | {2{power_cycled_flag}};

  wire [1:0] evt_hit;
  wire [1:0] lim_exp;
  wire [1:0] main_exp;
  wire [1:0] main_run = (act_uv | act_ov | act_oc) & ch_mask;

  // channel 1 always uses its own fields
  fsup_chan #(
    .LIM_W(LIM_W),
    .MAIN_W(MAIN_W)
  ) u_ch1 (
    .ref_clk(ref_clk),
    .srst(srst),
    .tick(chan_tick[0]),
    .clr(chan_clr[0]),
    .evt(evt_q[0]),
    .evt_thr(evt_thr_of(limit_cfg_ff[5:4])),
    .lim_max(lim_max_of(ltimer_cfg_ff[1:0])),
    .main_run(main_run[0]),
    .main_max(main_max_of(mtimer_cfg_ff[3:0])),
    .evt_hit(evt_hit[0]),
    .lim_exp(lim_exp[0]),
    .main_exp(main_exp[0])
  );

  // channel 2 timers stand still in dual phase (held in clear)
  fsup_chan #(
    .LIM_W(LIM_W),
    .MAIN_W(MAIN_W)
  ) u_ch2 (
    .ref_clk(ref_clk),
    .srst(srst),
    .tick(chan_tick[1]),
    .clr(chan_clr[1] | dual_phase_mode),
    .evt(evt_q[1]),
    .evt_thr(evt_thr_of(limit_cfg_ff[7:6])),
    .lim_max(lim_max_of(ltimer_cfg_ff[3:2])),
    .main_run(main_run[1]),
    .main_max(main_max_of(mtimer_cfg_ff[7:4])),
    .evt_hit(evt_hit[1]),
    .lim_exp(lim_exp[1]),
    .main_exp(main_exp[1])
  );

  // in dual phase channel 1 results steer both channels
  wire [1:0] hit_eff = dual_phase_mode ? {2{evt_hit[0]}} : evt_hit;
  wire [1:0] lexp_eff = dual_phase_mode ? {2{lim_exp[0]}} : lim_exp;
  wire [1:0] mexp_eff = dual_phase_mode ? {2{main_exp[0]}} : main_exp;

  // latched fault sources per channel, from the latch configuration
  wire [1:0] latch_hit = (act_uv & fault_latch_cfg[1:0])
    | (act_ov & fault_latch_cfg[3:2])
    | (act_oc & fault_latch_cfg[5:4])
    | (hit_eff & fault_latch_cfg[7:6]);
  wire [1:0] latch_eff = dual_phase_mode ? {2{latch_hit[0]}} : latch_hit;

  // present fault conditions for each status register
  wire [7:0] cond1 = {s_rto, 1'b0, 1'b0, s_tw, s_ov & ch_mask,
    s_uv & ch_mask};
  wire [7:0] cond2 = {s_uc & ch_mask, s_oc & ch_mask,
    evt_hit & ch_mask, s_iso};

  // status, read tracking and latched-off next state
  always @* begin
    nxt_status1 = status1_ff | cond1;
    nxt_status2 = status2_ff | cond2;
    nxt_rd_state = rd_state_ff;
    nxt_latch_off = latch_off_ff & ~channel_enable_wr;
    nxt_latch_off = nxt_latch_off | latch_eff;
    case (rd_state_ff)
      ST_IDLE: begin
        if (reg_rd && reg_addr == `FSUP_ADDR_STATUS1) begin
          nxt_rd_state = ST_PEND1;
        end else if (reg_rd && reg_addr == `FSUP_ADDR_STATUS2) begin
          nxt_rd_state = ST_PEND2;
        end
      end
      ST_PEND1: begin
        // clear only once the response has gone out
        if (reg_rd_done) begin
          nxt_status1 = (status1_ff & cond1) | cond1;
          nxt_rd_state = ST_IDLE;
        end
      end
      ST_PEND2: begin
        if (reg_rd_done) begin
          nxt_status2 = (status2_ff & cond2) | cond2;
          nxt_rd_state = ST_IDLE;
        end
      end
      default: begin
        nxt_rd_state = ST_IDLE;
      end
    endcase
  end

  // configuration registers written by the host
  always @(posedge ref_clk) begin
    if (srst) begin
      limit_cfg_ff <= `FSUP_RST_LIMIT_CFG;
      ltimer_cfg_ff <= `FSUP_RST_LTIMER_CFG;
      mtimer_cfg_ff <= `FSUP_RST_MTIMER_CFG;
      enable1_ff <= `FSUP_RST_ENABLE1;
      enable2_ff <= `FSUP_RST_ENABLE2;
    end else if (reg_wr) begin
      case (reg_addr)
        `FSUP_ADDR_LIMIT_CFG: limit_cfg_ff <= reg_wdata;
        `FSUP_ADDR_LTIMER_CFG: ltimer_cfg_ff <= {4'h0, reg_wdata[3:0]};
        `FSUP_ADDR_MTIMER_CFG: mtimer_cfg_ff <= reg_wdata;
        `FSUP_ADDR_ENABLE1: enable1_ff <= reg_wdata;
        `FSUP_ADDR_ENABLE2: enable2_ff <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
        default: limit_cfg_ff <= limit_cfg_ff;
      endcase
    end
  end

  // status and tracking state; power cycled comes up set
  always @(posedge ref_clk) begin
    if (srst) begin
      status1_ff <= `FSUP_RST_STATUS1;
      status2_ff <= `FSUP_RST_STATUS2;
      rd_state_ff <= ST_IDLE;
      latch_off_ff <= 2'b00;
      limit_sync_d_ff <= 2'b00;
    end else begin
      status1_ff <= nxt_status1;
      status2_ff <= nxt_status2;
      rd_state_ff <= nxt_rd_state;
      latch_off_ff <= nxt_latch_off;
      limit_sync_d_ff <= s_limit;
    end
  end

  // read data is captured at the end of the command transfer
  always @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `FSUP_ADDR_LIMIT_CFG: reg_rdata <= limit_cfg_ff;
        `FSUP_ADDR_LTIMER_CFG: reg_rdata <= ltimer_cfg_ff;
        `FSUP_ADDR_MTIMER_CFG: reg_rdata <= mtimer_cfg_ff;
        `FSUP_ADDR_STATUS1: reg_rdata <= status1_ff;
        `FSUP_ADDR_STATUS2: reg_rdata <= status2_ff;
        `FSUP_ADDR_ENABLE1: reg_rdata <= enable1_ff;
        `FSUP_ADDR_ENABLE2: reg_rdata <= enable2_ff;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // channel outputs; a blocked channel may not run at all
  always @(posedge ref_clk) begin
    if (srst) begin
      chan_shutdown <= 2'b11;
      fault_pin_oe <= 2'b00;
    end else begin
      chan_shutdown <= latch_off_ff | lexp_eff | mexp_eff
        | {2{power_cycled_flag}};
      fault_pin_oe <= act_uv | act_ov | act_oc | act_iso | act_fbo
        | (hit_eff & en_lim);
    end
  end
endmodule // fsup_top
`default_nettype wire

// File: testbench/fsup_assertions.sv
/*
  Checker of port-level timing for fsup_top.
  Assumes it is bound to fsup_top, one clock ref_clk, srst sync active high.
*/
`timescale 1ns/1ns
`default_nettype none
module fsup_chk #(
  parameter LIM_W = 6,
  parameter MAIN_W = 14
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic reg_rd_done,
  input wire logic [7:0] reg_rdata,
  input wire logic power_cycled_flag,
  input wire logic [3:0] current_limit_threshold_select,
  input wire logic [1:0] chan_shutdown,
  input wire logic [1:0] fault_pin_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // main timer config written, a quiet cycle, then read back
  sequence s_main_wr;
    reg_wr && reg_addr == 8'h10;
  endsequence
  sequence s_main_rd;
    reg_rd && reg_addr == 8'h10;
  endsequence

  a_reset_outputs: assert property (
    $fell(srst) |-> chan_shutdown == 2'h3 && fault_pin_oe == 2'h0)
    else $error("outputs not at reset state");
  a_pc_holds_off: assert property (
    power_cycled_flag |-> chan_shutdown == 2'h3)
    else $error("channel released while power cycled");
  a_pc_keeps_set: assert property (
    power_cycled_flag && !reg_rd_done |=> power_cycled_flag)
    else $error("power cycled flag lost without read done");
  a_pc_clear_time: assert property (
    $fell(power_cycled_flag) |-> $past(reg_rd_done))
    else $error("power cycled flag cleared at wrong time");
  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (
    reg_rd && (reg_addr < 8'h0e || reg_addr > 8'h14) |=> reg_rdata == 8'h00)
    else $error("unmapped offset read not zero");
  a_thr_follows: assert property (
    reg_wr && reg_addr == 8'h0e |=> current_limit_threshold_select == $past(reg_wdata[3:0]))
    else $error("threshold select not updated");
  a_reserved_zero: assert property (
    reg_rd && reg_addr == 8'h0f |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved timer bits read nonzero");
  a_main_readback: assert property (
    s_main_wr ##1 !reg_wr ##1 s_main_rd |=> reg_rdata == $past(reg_wdata, 3))
    else $error("main timer config readback differs");
endmodule // fsup_chk

bind fsup_top fsup_chk #(.LIM_W(LIM_W), .MAIN_W(MAIN_W)) u_chk (
  .ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rd_done(reg_rd_done),
  .reg_rdata(reg_rdata), .power_cycled_flag(power_cycled_flag),
  .current_limit_threshold_select(current_limit_threshold_select),
  .chan_shutdown(chan_shutdown), .fault_pin_oe(fault_pin_oe)
);
`default_nettype wire

// File: testbench/fsup_host.sv
/*
  Host model: issues the decoded register strobes of the serial front end.
  Assumes ref_clk is the design clock; drives only off its falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module fsup_host (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  output logic reg_rd_done,
  output logic [1:0] channel_enable_wr
);
  // idle bus from time zero
  initial begin
    {reg_wr, reg_rd, reg_rd_done} = 3'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    channel_enable_wr = 2'h0;
  end
  // one write strobe; data scrambled once released so stale values never help
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // command transfer, then optionally the end of the response transfer
  task automatic rd(input logic [7:0] a, input logic fin, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    if (fin) begin
      @(negedge ref_clk);
      reg_rd_done = 1'b1;
      @(negedge ref_clk);
      reg_rd_done = 1'b0;
    end
  endtask
  // channel enable written back to one after a latched shutdown
  task automatic en(input logic [1:0] ch);
    @(negedge ref_clk);
    channel_enable_wr = ch;
    @(negedge ref_clk);
    channel_enable_wr = 2'h0;
  endtask
endmodule // fsup_host
`default_nettype wire

// File: testbench/testbench.sv
/*
  Self-checking bench for fsup_top: register traffic through fsup_host,
  fault levels and channel ticks from here. Assumes 10 MHz ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic ref_clk, srst, cv_mode, dual_phase_mode, cond_rto, cond_tw;
  logic [1:0] cond_uv, cond_ov, cond_uc, cond_oc, cond_iso, cond_fbo, cond_limit;
  logic [1:0] chan_tick, chan_running, soft_start_active, channel_enable_wr;
  logic [1:0] chan_shutdown, fault_pin_out, fault_pin_oe;
  logic [7:0] fault_latch_cfg, reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rd_done, power_cycled_flag;
  logic [3:0] current_limit_threshold_select;
  int num_errors = 0;
  int num_checks = 0;
  logic [7:0] rst_vals [7] = '{8'h0f, 8'h0a, 8'h99, 8'h20, 8'h00, 8'h3c, 8'h0f};

  fsup_host host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rd_done(reg_rd_done), .channel_enable_wr(channel_enable_wr));
  fsup_top dut (.ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rd_done(reg_rd_done),
    .reg_rdata(reg_rdata), .cond_uv(cond_uv), .cond_ov(cond_ov), .cond_uc(cond_uc),
    .cond_oc(cond_oc), .cond_iso(cond_iso), .cond_fbo(cond_fbo),
    .cond_limit(cond_limit), .cond_rto(cond_rto), .cond_tw(cond_tw),
    .chan_tick(chan_tick), .chan_running(chan_running),
    .soft_start_active(soft_start_active), .channel_enable_wr(channel_enable_wr),
    .fault_latch_cfg(fault_latch_cfg), .cv_mode(cv_mode),
    .dual_phase_mode(dual_phase_mode), .power_cycled_flag(power_cycled_flag),
    .current_limit_threshold_select(current_limit_threshold_select),
    .chan_shutdown(chan_shutdown), .fault_pin_out(fault_pin_out),
    .fault_pin_oe(fault_pin_oe));

  // 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic fin, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, fin, d);
    chk(d, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // ticks two cycles apart so each is its own pulse
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      chan_tick = 2'h1;
      @(negedge ref_clk);
      chan_tick = 2'h0;
    end
  endtask
  // level held long enough to cross the synchroniser both ways
  task automatic lim_evt;
    cond_limit = 2'h1;
    cyc(6);
    cond_limit = 2'h0;
    cyc(6);
  endtask
  // bounded wait; a miss ends the run
  task automatic wait_sd(input logic [1:0] exp);
    for (int i = 0; i < 8 && chan_shutdown !== exp; i++) @(negedge ref_clk);
    chk({6'h0, chan_shutdown}, {6'h0, exp});
    if (chan_shutdown !== exp) wrap_up;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    wrap_up;
  end

  initial begin
    {srst, cv_mode, dual_phase_mode, cond_rto, cond_tw} = 5'h10;
    {cond_uv, cond_ov, cond_uc, cond_oc, cond_iso, cond_fbo, cond_limit} = 14'h0000;
    {chan_tick, chan_running, soft_start_active} = 6'h00;
    fault_latch_cfg = 8'h00;
    cyc(16);
    srst = 1'b0;
    // reset state and register defaults; status read without response end
    chk({chan_shutdown, fault_pin_oe, 3'h0, power_cycled_flag}, 8'hc1);
    chk({6'h0, fault_pin_out}, 8'h00);
    for (int i = 0; i < 7; i++) rchk(8'(8'h0e + i), 1'b0, rst_vals[i]);
    rchk(8'h20, 1'b0, 8'h00);
    chk({7'h0, power_cycled_flag}, 8'h01);
    rchk(8'h11, 1'b1, 8'h20);
    // shutdown is registered one edge behind the flag
    cyc(1);
    chk({power_cycled_flag, 5'h0, chan_shutdown}, 8'h00);
    // config readback and reserved bits
    host.wr(8'h0e, 8'h5a);
    chk({4'h0, current_limit_threshold_select}, 8'h0a);
    rchk(8'h0e, 1'b0, 8'h5a);
    host.wr(8'h0f, 8'hff);
    rchk(8'h0f, 1'b0, 8'h0f);
    host.wr(8'h14, 8'hff);
    rchk(8'h14, 1'b0, 8'hbf);
    host.wr(8'h14, 8'h0f);
    host.wr(8'h0f, 8'h00);
    host.wr(8'h0e, 8'h10);
    // status stays while its fault is present
    {cond_rto, cond_tw} = 2'h3;
    cyc(6);
    rchk(8'h11, 1'b1, 8'h90);
    rchk(8'h11, 1'b1, 8'h90);
    {cond_rto, cond_tw} = 2'h0;
    cyc(6);
    rchk(8'h11, 1'b1, 8'h90);
    rchk(8'h11, 1'b0, 8'h00);
    // enables and ramp masking on the fault pin
    chan_running = 2'h3;
    cond_uv = 2'h1;
    cyc(6);
    chk({6'h0, fault_pin_oe}, 8'h00);
    host.wr(8'h13, 8'h3d);
    cyc(2);
    chk({6'h0, fault_pin_oe}, 8'h01);
    soft_start_active = 2'h1;
    cyc(2);
    chk({6'h0, fault_pin_oe}, 8'h00);
    host.wr(8'h13, 8'h7d);
    cyc(2);
    chk({6'h0, fault_pin_oe}, 8'h01);
    {cond_uv, soft_start_active} = 4'h0;
    cyc(6);
    chk({6'h0, fault_pin_oe}, 8'h00);
    // latched fault stays off until enable written
    fault_latch_cfg = 8'h01;
    cond_uv = 2'h1;
    wait_sd(2'h1);
    cond_uv = 2'h0;
    cyc(6);
    chk({6'h0, chan_shutdown}, 8'h01);
    host.en(2'h1);
    wait_sd(2'h0);
    fault_latch_cfg = 8'h00;
    rchk(8'h11, 1'b1, 8'h01);
    // dual phase hides channel 2
    dual_phase_mode = 1'b1;
    host.wr(8'h13, 8'h7f);
    cond_uv = 2'h2;
    cyc(6);
    chk({6'h0, fault_pin_oe}, 8'h00);
    rchk(8'h11, 1'b1, 8'h00);
    dual_phase_mode = 1'b0;
    cyc(2);
    chk({6'h0, fault_pin_oe}, 8'h02);
    cond_uv = 2'h0;
    cyc(6);
    rchk(8'h11, 1'b1, 8'h02);
    // analog-only overvoltage leaves the pin alone; feedback open still acts
    host.wr(8'h14, 8'h8f);
    {cond_ov, cond_fbo} = 4'h6;
    cyc(6);
    chk({6'h0, fault_pin_oe}, 8'h02);
    host.wr(8'h14, 8'h0f);
    cyc(2);
    chk({6'h0, fault_pin_oe}, 8'h03);
    {cond_ov, cond_fbo} = 4'h0;
    cyc(6);
    rchk(8'h11, 1'b1, 8'h04);
    // four limit events, then a limit timer of four ticks
    repeat (3) lim_evt;
    rchk(8'h12, 1'b0, 8'h00);
    {cond_uc, cond_oc, cond_limit} = 6'h19;
    cyc(6);
    rchk(8'h12, 1'b0, 8'h64);
    ticks(3);
    chk({6'h0, chan_shutdown}, 8'h00);
    ticks(1);
    wait_sd(2'h1);
    chan_running = 2'h0;
    wait_sd(2'h0);
    {cond_uc, cond_oc, cond_limit} = 6'h00;
    cyc(6);
    rchk(8'h12, 1'b1, 8'h64);
    rchk(8'h12, 1'b0, 8'h00);
    // main timer at 1000 ticks
    chan_running = 2'h1;
    host.wr(8'h10, 8'h01);
    rchk(8'h10, 1'b0, 8'h01);
    cond_uv = 2'h1;
    cyc(6);
    ticks(999);
    chk({6'h0, chan_shutdown}, 8'h00);
    ticks(1);
    wait_sd(2'h1);
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
